// ==== src/arp_pkg.sv ====
/*
 * constants, field layouts and state types for the converter result
 * readout port.
 * assumes a single 125 mhz system clock and an apb register bus.
 */
package arp_pkg;

   // ========================================================
   // register map (byte addresses)
   // ========================================================
   localparam logic [11:0] ADDR_CFG    = 12'h000; // configuration, rw
   localparam logic [11:0] ADDR_STATUS = 12'h004; // live status, ro
   localparam logic [11:0] ADDR_RESULT = 12'h008; // last result, ro

   // ========================================================
   // timing
   // ========================================================
   localparam int          CLK_MHZ      = 125;  // system clock rate
   localparam int          CONV_TIME_NS = 1250; // conversion phase length
   localparam logic [15:0] CONV_CYCLES  =
      16'((CONV_TIME_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0]  MCLK_BASE    = 8'h04; // half period per step

   // ========================================================
   // widths, positions and encodings
   // ========================================================
   localparam logic [4:0]  RES_BITS  = 5'h12;   // 18 result bits
   localparam logic [4:0]  LAST_BIT  = 5'h11;   // index of final bit
   localparam logic [1:0]  WID_18    = 2'h0;    // 18-bit parallel
   localparam logic [1:0]  WID_16    = 2'h1;    // 16-bit parallel
   localparam logic [1:0]  WID_8     = 2'h2;    // 8-bit parallel
   localparam logic [1:0]  WID_SER   = 2'h3;    // serial on the bus pins
   localparam logic [8:0]  CFG_RESET = 9'h000;  // config after reset

   // configuration register, bit 0 upward from the bottom field
   typedef struct packed {
      logic       chain_en;            // daisy chain enable
      logic       frame_inv;           // invert frame_valid
      logic       sclk_inv;            // invert generated clock
      logic [1:0] master_clk_divider;  // generated clock slow-down
      logic       clock_source_sel;    // 0 internal, 1 external
      logic       output_format_sel;   // 1 straight binary, except on the 18-bit parallel bus
      logic       width_sel_1;         // bus width select, high bit
      logic       width_sel_0;         // bus width select, low bit
   } arp_cfg_t;

   // complete state of the readout block
   typedef struct packed {
      logic [1:0]  cs_s;       // chip select n synchroniser
      logic [1:0]  rd_s;       // read strobe n synchroniser
      logic [1:0]  cnv_s;      // convert start n synchroniser
      logic [1:0]  sck_s;      // external serial clock synchroniser
      logic [1:0]  chn_s;      // readmode / chain input synchroniser
      logic        cnv_prev;   // previous synced convert start
      logic        sck_prev;   // previous synced serial clock
      logic        rd_prev;    // previous synced read strobe
      arp_cfg_t    cfg;        // software configuration
      logic        conv_busy;  // conversion phase running
      logic [15:0] conv_cnt;   // cycles left in conversion
      logic [17:0] result;     // last completed result
      logic [17:0] sr;         // serial shift register
      logic [4:0]  bit_cnt;    // bits shifted out so far
      logic        xfer;       // master transfer in progress
      logic        rdc_read;   // slave read began during conversion
      logic        chain_bit;  // chain input captured on rising edge
      logic [7:0]  mdiv_cnt;   // generated clock divider
      logic        sclk_int;   // generated clock level
      logic [1:0]  word_ptr;   // parallel word / byte pointer
      logic [17:0] data_o;     // parallel bus output
      logic        data_oe_n;  // bus / serial data enable, low drives
      logic        ser_o;      // serial data output
      logic        sclk_o;     // generated clock output
      logic        frame_o;    // frame valid output
      logic        mst_oe_n;   // clock / frame enable, low drives
      logic        busy_o;     // busy flag, conversion or read-after-conversion master shift
      logic        ovr_o;      // read overrun pulse
      logic [31:0] prdata;     // apb read data
      logic        pready;     // apb ready
      logic        pslverr;    // apb error
   } arp_state_t;

endpackage : arp_pkg

// ==== src/arp_readout.sv ====
/*
 * result readout port of an 18-bit sampling converter: parallel bus of
 * 18, 16 or 8 bits, or a serial link on the same pins as clock master
 * or slave, with conversion sequencing and apb configuration.
 * assumes core_result is valid at the end of each conversion phase and
 * that all pins other than the apb come from outside the clock domain.
 */
`timescale 1ns/1ns

module arp_readout (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [17:0] core_result,
   input  wire logic        convert_start_n,
   input  wire logic        chip_select_n,
   input  wire logic        read_strobe_n,
   input  wire logic        sclk_in,
   input  wire logic        readmode_chain_in,
   output logic      [17:0] data_out,
   output logic             data_oe_n,
   output logic             serial_out,
   output logic             sclk_out,
   output logic             frame_valid,
   output logic             master_oe_n,
   output logic             busy,
   output logic             read_overrun_flag
);

   // ========================================================
   // helpers
   // ========================================================
   // straight binary flips the sign bit of the twos complement code
   function automatic logic [17:0] fmt_res(input logic [17:0] r,
                                          input logic        sb);
      fmt_res = {r[17] ^ sb, r[16:0]};
   endfunction : fmt_res

   // word presented on the parallel bus for a width and pointer
   function automatic logic [17:0] par_word(input logic [17:0] r,
                                           input logic [1:0]  w,
                                           input logic [1:0]  p);
      case (w)
         arp_pkg::WID_16: par_word = (p == 2'h0) ? {2'h0, r[17:2]}
                                                 : {16'h0000, r[1:0]};
         arp_pkg::WID_8: begin
            case (p)
               2'h0:    par_word = {10'h000, r[17:10]};
               2'h1:    par_word = {10'h000, r[9:2]};
               default: par_word = {16'h0000, r[1:0]};
            endcase
         end
         default: par_word = r;
      endcase
   endfunction : par_word

   // generated clock half period in system cycles
   function automatic logic [7:0] half_cyc(input logic [1:0] d);
      half_cyc = ({6'h00, d} + 8'h01) * arp_pkg::MCLK_BASE;
   endfunction : half_cyc

   // ========================================================
   // state and decoded conditions
   // ========================================================
   arp_pkg::arp_state_t st_ff;     // registered state
   arp_pkg::arp_state_t nxt_st;    // next state
   logic [1:0]          width;     // width select pair
   logic                serial;    // serial link in use
   logic                master;    // serial with generated clock
   logic                slave;     // serial with external clock
   logic                rac_m;     // master, read after conversion
   logic                sel;       // select and read both low
   logic                sck_rise;  // external clock rising
   logic                sck_fall;  // external clock falling
   logic                cnv_fall;  // convert start falling
   logic                rd_rise;   // end of a parallel read
   logic                conv_end;  // last cycle of conversion

   assign width    = {st_ff.cfg.width_sel_1, st_ff.cfg.width_sel_0};
   assign serial   = (width == arp_pkg::WID_SER);
   assign master   = serial && !st_ff.cfg.clock_source_sel;
   assign slave    = serial && st_ff.cfg.clock_source_sel;
   assign rac_m    = master && !st_ff.chn_s[1];
   assign sel      = !st_ff.cs_s[1] && !st_ff.rd_s[1];
   assign sck_rise = st_ff.sck_s[1] && !st_ff.sck_prev;
   assign sck_fall = !st_ff.sck_s[1] && st_ff.sck_prev;
   assign cnv_fall = !st_ff.cnv_s[1] && st_ff.cnv_prev;
   assign rd_rise  = st_ff.rd_s[1] && !st_ff.rd_prev;
   assign conv_end = st_ff.conv_busy && (st_ff.conv_cnt == 16'h0001);

   // ========================================================
   // next state
   // ========================================================
   always_comb begin
      nxt_st = st_ff;
      // two-stage synchronisers, edge history from second stage
      nxt_st.cs_s     = {st_ff.cs_s[0], chip_select_n};
      nxt_st.rd_s     = {st_ff.rd_s[0], read_strobe_n};
      nxt_st.cnv_s    = {st_ff.cnv_s[0], convert_start_n};
      nxt_st.sck_s    = {st_ff.sck_s[0], sclk_in};
      nxt_st.chn_s    = {st_ff.chn_s[0], readmode_chain_in};
      nxt_st.cnv_prev = st_ff.cnv_s[1];
      nxt_st.sck_prev = st_ff.sck_s[1];
      nxt_st.rd_prev  = st_ff.rd_s[1];
      nxt_st.ovr_o    = 1'b0;

      // apb: one wait state, write lands on the completing edge
      nxt_st.pready  = 1'b0;
      nxt_st.pslverr = 1'b0;
      if (psel && penable && !st_ff.pready) begin
         nxt_st.pready = 1'b1;
         case (paddr)
            arp_pkg::ADDR_CFG:    nxt_st.prdata = {23'h0, st_ff.cfg};
            arp_pkg::ADDR_STATUS: nxt_st.prdata = {22'h0, st_ff.bit_cnt,
               st_ff.rdc_read, st_ff.xfer, st_ff.busy_o,
               st_ff.conv_busy, sel};
            arp_pkg::ADDR_RESULT: nxt_st.prdata = {14'h0, st_ff.result};
            default: begin
               // unmapped address answers with an error
               nxt_st.prdata  = 32'h0000_0000;
               nxt_st.pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && st_ff.pready && pwrite &&
          paddr == arp_pkg::ADDR_CFG) begin
         nxt_st.cfg = arp_pkg::arp_cfg_t'(pwdata[8:0]);
      end

      // master: divided clock, data moves on the falling edge only
      if (!master) begin
         nxt_st.xfer     = 1'b0;
         nxt_st.sclk_int = 1'b0;
      end else if (st_ff.xfer) begin
         if (st_ff.mdiv_cnt == half_cyc(st_ff.cfg.master_clk_divider)
                              - 8'h01) begin
            nxt_st.mdiv_cnt = 8'h00;
            nxt_st.sclk_int = !st_ff.sclk_int;
            if (st_ff.sclk_int) begin
               // falling edge: bit held from here through next fall
               nxt_st.sr      = {st_ff.sr[16:0], 1'b0};
               nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
               if (st_ff.bit_cnt == arp_pkg::LAST_BIT) begin
                  nxt_st.xfer = 1'b0;
               end
            end
         end else begin
            nxt_st.mdiv_cnt = st_ff.mdiv_cnt + 8'h01;
         end
      end

      // slave: external clock gated by select and read
      if (slave && sel) begin
         if (sck_rise) begin
            nxt_st.chain_bit = st_ff.chn_s[1];
         end
         if (sck_fall) begin
            if (st_ff.bit_cnt == 5'h00 && st_ff.conv_busy) begin
               nxt_st.rdc_read = 1'b1;
            end
            // chain data only in read after conversion
            nxt_st.sr = {st_ff.sr[16:0],
                         st_ff.cfg.chain_en && !nxt_st.rdc_read
                         && st_ff.chain_bit};
            if (st_ff.bit_cnt != arp_pkg::RES_BITS) begin
               nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
            end
         end
      end

      // conversion sequencing; loads override shifting
      if (!st_ff.conv_busy && cnv_fall) begin
         // a start while busy is ignored
         nxt_st.conv_busy = 1'b1;
         nxt_st.conv_cnt  = arp_pkg::CONV_CYCLES;
         if (master && !rac_m) begin
            // send the previous result during this conversion
            nxt_st.sr       = fmt_res(st_ff.result,
                                      st_ff.cfg.output_format_sel);
            nxt_st.bit_cnt  = 5'h00;
            nxt_st.xfer     = 1'b1;
            nxt_st.sclk_int = 1'b0;
            nxt_st.mdiv_cnt = 8'h00;
         end
      end else if (conv_end) begin
         nxt_st.conv_busy = 1'b0;
         nxt_st.conv_cnt  = 16'h0000;
         nxt_st.result    = core_result;
         nxt_st.word_ptr  = 2'h0;
         if (slave && st_ff.rdc_read &&
             st_ff.bit_cnt != arp_pkg::RES_BITS) begin
            nxt_st.ovr_o = 1'b1;
         end
         if (slave || rac_m) begin
            // a read begun after conversion kept its bits until here
            nxt_st.sr       = fmt_res(core_result,
                                      st_ff.cfg.output_format_sel);
            nxt_st.bit_cnt  = 5'h00;
            nxt_st.rdc_read = 1'b0;
         end
         if (rac_m) begin
            nxt_st.xfer     = 1'b1;
            nxt_st.sclk_int = 1'b0;
            nxt_st.mdiv_cnt = 8'h00;
         end
      end else if (st_ff.conv_busy) begin
         nxt_st.conv_cnt = st_ff.conv_cnt - 16'h0001;
      end

      // parallel pointer steps at the end of each read strobe, unless a conversion ends in that cycle
      if (!serial && rd_rise && !st_ff.cs_s[1] && !conv_end) begin
         case (width)
            arp_pkg::WID_16: nxt_st.word_ptr = st_ff.word_ptr ^ 2'h1;
            arp_pkg::WID_8:  nxt_st.word_ptr = (st_ff.word_ptr == 2'h2)
                                ? 2'h0 : st_ff.word_ptr + 2'h1;
            default:         nxt_st.word_ptr = 2'h0;
         endcase
      end

      // pin outputs, all registered
      if (serial) begin
         nxt_st.data_o = 18'h00000;
      end else if (width == arp_pkg::WID_18) begin
         nxt_st.data_o = nxt_st.result;
      end else begin
         nxt_st.data_o = par_word(fmt_res(nxt_st.result,
                                  st_ff.cfg.output_format_sel),
                                  width, nxt_st.word_ptr);
      end
      nxt_st.data_oe_n = !sel;
      nxt_st.mst_oe_n  = !(sel && master);
      nxt_st.ser_o     = serial && nxt_st.sr[17];
      nxt_st.sclk_o    = master && (nxt_st.sclk_int ^ st_ff.cfg.sclk_inv);
      nxt_st.frame_o   = master && (nxt_st.xfer ^ st_ff.cfg.frame_inv);
      nxt_st.busy_o    = nxt_st.conv_busy || (rac_m && nxt_st.xfer);
   end

   // ========================================================
   // state register
   // ========================================================
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff           <= '0;
         st_ff.cs_s      <= 2'h3;
         st_ff.rd_s      <= 2'h3;
         st_ff.cnv_s     <= 2'h3;
         st_ff.cnv_prev  <= 1'b1;
         st_ff.rd_prev   <= 1'b1;
         st_ff.cfg       <= arp_pkg::CFG_RESET;
         st_ff.data_oe_n <= 1'b1;
         st_ff.mst_oe_n  <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata            = st_ff.prdata;
   assign pready            = st_ff.pready;
   assign pslverr           = st_ff.pslverr;
   assign data_out          = st_ff.data_o;
   assign data_oe_n         = st_ff.data_oe_n;
   assign serial_out        = st_ff.ser_o;
   assign sclk_out          = st_ff.sclk_o;
   assign frame_valid       = st_ff.frame_o;
   assign master_oe_n       = st_ff.mst_oe_n;
   assign busy              = st_ff.busy_o;
   assign read_overrun_flag = st_ff.ovr_o;

   // ========================================================
   // checks
   // ========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_FLOAT_DESELECT: assert property (
      (st_ff.cs_s[1] || st_ff.rd_s[1]) |=> data_oe_n && master_oe_n)
      else $error("outputs driven while not selected");

   AST_FORMAT_16: assert property (
      (width == arp_pkg::WID_16 && st_ff.word_ptr == 2'h0 && !conv_end
       && !rd_rise) |=> data_out[15] ==
       ($past(st_ff.result[17]) ^ $past(st_ff.cfg.output_format_sel)))
      else $error("16-bit word sign bit has wrong coding");

   AST_SERIAL_BUS_QUIET: assert property (
      serial |=> data_out == 18'h00000)
      else $error("parallel bus active in serial mode");

   AST_MASTER_18_BITS: assert property (
      $fell(st_ff.xfer) && master |-> st_ff.bit_cnt == arp_pkg::RES_BITS)
      else $error("master frame ended without 18 bits");

   AST_BUSY_HELD: assert property (
      rac_m && st_ff.xfer && !$rose(st_ff.xfer) |-> busy)
      else $error("busy fell before master shift finished");

   AST_DIVIDER_HOLD: assert property (
      master && st_ff.xfer && st_ff.mdiv_cnt == 8'h00
      && st_ff.cfg.master_clk_divider == 2'h1 && !cnv_fall && !conv_end
      |=> $stable(st_ff.sclk_int) [*7])
      else $error("generated clock toggled early");

   AST_SLAVE_GATED: assert property (
      slave && !sel && !conv_end |=> $stable(st_ff.sr))
      else $error("slave shifted while not selected");

   AST_OVERRUN_CAUSE: assert property (
      read_overrun_flag |-> $past(conv_end) && $past(st_ff.rdc_read)
      && $past(st_ff.bit_cnt) != arp_pkg::RES_BITS)
      else $error("overrun pulse without unfinished read");

   AST_NO_RESTART: assert property (
      st_ff.conv_busy && !conv_end |=>
      st_ff.conv_busy && st_ff.conv_cnt == $past(st_ff.conv_cnt) - 16'h1)
      else $error("conversion restarted or aborted");

endmodule : arp_readout

// ==== sim/arp_host_model.sv ====
/*
 * host side of the serial link: makes the external serial clock for a
 * frame and shifts in the converter's serial data.
 * assumes the port shifts after a falling clock edge and holds each bit
 * through the following rising and falling edges.
 */
`timescale 1ns/1ns
// ========================================================
// serial host model
// ========================================================
module arp_host_model (
   input  wire logic       go,     // rising edge starts a frame
   input  wire logic [4:0] nbits,  // clock pulses in the frame
   input  wire logic       sdata,  // serial data from the port
   output logic            sclk,   // external clock, idles low
   output logic [17:0]     word,   // bits taken in, msb first
   output logic            done    // frame finished
);
   // idle state: clock low, nothing read yet
   initial begin
      sclk = 1'b0;
      word = 18'h0;
      done = 1'b0;
   end
   // clock runs only inside a frame, 64 ns period, polarity 0
   always @(posedge go) begin
      done = 1'b0;
      #3;
      for (int i = 0; i < 32'(nbits); i++) begin
         #32 sclk = 1'b1;
         #32 word = {word[16:0], sdata};
         sclk = 1'b0;
      end
      done = 1'b1;
   end
endmodule : arp_host_model

// ==== sim/arp_readout_test.sv ====
/*
 * self-checking bench of the result readout port: apb setup, parallel
 * reads at each width, slave and master serial reads, overrun.
 * assumes the design package and the serial host model are compiled.
 */
`timescale 1ns/1ns
module arp_readout_test;
   // ========================================================
   // signals
   // ========================================================
   logic clk, reset, psel, penable, pwrite, pready, pslverr, go, done;
   logic cnv_n, cs_n, rd_n, sclk, busy, ovr, ser, mclk, doe_n;
   logic chn, frm, moe_n, mprev;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [17:0] core, dout, word, mword;
   logic [4:0]  nb;
   logic        e;
   int          err_total, n_compared, cyc, rises, ovr_n, tick, frames;
   arp_readout dut_u (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core_result(core), .convert_start_n(cnv_n),
      .chip_select_n(cs_n), .read_strobe_n(rd_n), .sclk_in(sclk),
      .readmode_chain_in(chn), .data_out(dout), .data_oe_n(doe_n),
      .serial_out(ser), .sclk_out(mclk), .frame_valid(frm),
      .master_oe_n(moe_n), .busy(busy), .read_overrun_flag(ovr));
   arp_host_model host_u (.go(go), .nbits(nb), .sdata(ser),
      .sclk(sclk), .word(word), .done(done));
   // ========================================================
   // tasks
   // ========================================================
   task tally_and_finish;
      if (err_total == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   // compare one value, report a mismatch
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      chk("apb_ready", 1, 32'(n < 20));
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // start a conversion and wait for busy to rise
   task start(input logic [17:0] r);
      core <= r;
      cnv_n <= 1'b0;
      wt(4);
      cnv_n <= 1'b1;
      for (int i = 0; i < 12 && busy !== 1'b1; i++)
         @(posedge clk);
   endtask : start
   // wait for busy to fall; count cycles, clock rises, frame and overrun
   task wait_idle;
      cyc = 0;
      rises = 0;
      ovr_n = 0;
      frames = 0;
      mprev = mclk;
      while (busy === 1'b1 && cyc < 900) begin
         @(posedge clk);
         cyc++;
         if (mclk === 1'b1 && mprev === 1'b0) begin
            // bit stands from the fall before through this rise
            rises++;
            mword = {mword[16:0], ser};
         end
         mprev = mclk;
         frames += 32'(frm === 1'b1);
         ovr_n += 32'(ovr === 1'b1);
      end
      wt(3);
      ovr_n += 32'(ovr === 1'b1);
   endtask : wait_idle
   // one host frame of n clock pulses, waits until the host is done
   task frame(input logic [4:0] n);
      nb <= n;
      go <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 400 && done !== 1'b1; i++)
         @(posedge clk);
      go <= 1'b0;
   endtask : frame
   // one parallel read cycle of the strobe
   task rdp(input string n, input logic [17:0] x, input logic [17:0] m);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      wt(6);
      chk(n, 32'(x), 32'(dout & m));
      rd_n <= 1'b1;
      wt(6);
   endtask : rdp
   // ========================================================
   // clock and timeout
   // ========================================================
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      tick++;
      if (tick == 30000) begin
         err_total++;
         tally_and_finish();
      end
   end
   // ========================================================
   // test sequence
   // ========================================================
   initial begin
      {psel, penable, pwrite, go, chn, err_total, n_compared, tick} = '0;
      {paddr, pwdata, core, nb} = '0;
      {reset, cnv_n, cs_n, rd_n} = 4'hf;
      wt(8);
      reset <= 1'b0;
      apb(1'b0, arp_pkg::ADDR_CFG, 32'h0);
      chk("cfg_reset", 32'h0, q);
      apb(1'b0, 12'h0f0, 32'h0);
      chk("unmapped_err", 1, 32'(e));
      start(18'h2b3c5);
      wait_idle();
      chk("conv_len", 1, 32'(cyc >= 150 && cyc <= 165));
      apb(1'b0, arp_pkg::ADDR_RESULT, 32'h0);
      chk("result_reg", 32'h2b3c5, q);
      rdp("par18", 18'h2b3c5, 18'h3ffff);
      rd_n <= 1'b0;
      wt(6);
      chk("oe_on", 0, 32'(doe_n));
      cs_n <= 1'b1;
      wt(6);
      chk("oe_off", 1, 32'(doe_n));
      apb(1'b1, arp_pkg::ADDR_CFG, 32'h001);
      start(18'h1a5c3);
      wait_idle();
      rdp("par16_w0", 18'h06970, 18'h0ffff);
      rdp("par16_w1", 18'h00003, 18'h0ffff);
      apb(1'b1, arp_pkg::ADDR_CFG, 32'h006);
      start(18'h1a5c3);
      wait_idle();
      rdp("par8_b0", 18'h000e9, 18'h000ff);
      rdp("par8_b1", 18'h00070, 18'h000ff);
      rdp("par8_b2", 18'h00003, 18'h000ff);
      // read the held result early in the next conversion
      start(18'h00000);
      rdp("par8_rdc", 18'h000e9, 18'h000ff);
      wait_idle();
      cs_n <= 1'b1;
      apb(1'b1, arp_pkg::ADDR_CFG, 32'h00b);
      start(18'h2d1e7);
      wait_idle();
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      wt(6);
      frame(5'h12);
      chk("slave_word", 32'h2d1e7, 32'(word));
      // leave one result unread, then read only four bits of it
      start(18'h15555);
      wait_idle();
      nb <= 5'h04;
      start(18'h0abcd);
      go <= 1'b1;
      wait_idle();
      go <= 1'b0;
      chk("overrun", 1, 32'(ovr_n));
      chk("rdc_bits", 32'h5, 32'(word[3:0]));
      for (int d = 0; d < 2; d++) begin
         apb(1'b1, arp_pkg::ADDR_CFG, 32'h003 | 32'(d << 4));
         start(18'h3c0f0);
         wait_idle();
         chk("mst_clocks", 18, rises);
         chk("mst_busy", 1, 32'(cyc >= 157 + 136 * (d + 1)
            && cyc <= 175 + 152 * (d + 1)));
         chk("mst_word", 32'h3c0f0, 32'(mword));
         chk("mst_frame", 144 * (d + 1), frames);
         chk("mst_oe", 0, 32'(moe_n));
      end
      // readmode high: previous result goes out during conversion
      chn <= 1'b1;
      apb(1'b1, arp_pkg::ADDR_CFG, 32'h003);
      start(18'h0f0f0);
      wait_idle();
      chk("rdc_word", 32'h3c0f0, 32'(mword));
      chk("rdc_busy", 32'(arp_pkg::CONV_CYCLES), cyc);
      // slave with chaining: the nineteenth bit is the chain input
      apb(1'b1, arp_pkg::ADDR_CFG, 32'h10b);
      start(18'h2d1e7);
      wait_idle();
      frame(5'h13);
      chk("chain_word", 32'h1a3cf, 32'(word));
      tally_and_finish();
   end
endmodule : arp_readout_test
